// ===== hw/plcbp_pkg.sv
// Package with the constants and types of the bit processor dispatch block.
package plcbp_pkg;
  localparam int ADDR_W = 15;
  localparam int CMD_W = 16;
  localparam int OPC_W = 8;
  localparam int PAR_W = 8;
  localparam int OPC_LSB = 8;
  localparam int UPC_W = 4;
  localparam int CTL_W = 8;
  localparam int BRK_DEPTH = 7;
  localparam int BRK_W = 3;
  localparam int EVT_W = 8;
  localparam int EVT_HW_INT = 0;
  localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
  localparam logic [EVT_W-1:0] EVT_RST = 8'h00;
  localparam logic [3:0] OPG_WORD = 4'h0;
  localparam logic [3:0] OPG_AND = 4'h1;
  localparam logic [3:0] OPG_OR = 4'h2;
  localparam logic [3:0] OPG_LOAD = 4'h3;
  localparam logic [3:0] OPG_SET = 4'h4;
  localparam logic [3:0] OPG_RESET = 4'h5;
  localparam logic [3:0] OPG_ANDOPEN = 4'h6;
  localparam logic [3:0] OPG_OROPEN = 4'h7;
  localparam logic [3:0] OPG_CLOSE = 4'h8;
  localparam logic [3:0] OPG_ASSIGN = 4'h9;
  localparam logic [3:0] OPG_IO = 4'hA;
  localparam logic [UPC_W-1:0] UPC_IDLE = 4'h0;
  localparam logic [UPC_W-1:0] UPC_LOGIC = 4'h1;
  localparam logic [UPC_W-1:0] UPC_STORE = 4'h3;
  localparam logic [UPC_W-1:0] UPC_BRK = 4'h5;
  localparam logic [UPC_W-1:0] UPC_WORD = 4'h7;
  localparam logic [UPC_W-1:0] UPC_IO = 4'h9;
  localparam logic [UPC_W-1:0] UPC_END = 4'hF;
  localparam int CTL_STEP = 0;
  localparam int CTL_DONE = 1;
  localparam int CTL_READ_OP = 2;
  localparam int CTL_WRITE_BIT = 3;
  localparam int CTL_BRK = 4;
  localparam int CTL_WORD = 5;
  localparam int CTL_IO = 6;
  localparam int CTL_LOGIC = 7;
  typedef enum logic [1:0] {
    EVT_NONE, EVT_BYTE_SPACE, EVT_BIT_SPACE, EVT_RSVD
  } plcbp_evt_t;
endpackage

// ===== hw/plcbp_bracket_stack.sv
// Bracket stack saving logic results per open nesting level.
`timescale 1ns/100ps
module plcbp_bracket_stack (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic push,
  input wire logic push_op_or,
  input wire logic push_rlo,
  input wire logic pop,
  output logic [plcbp_pkg::BRK_W-1:0] depth,
  output logic top_op_or,
  output logic top_rlo,
  output logic full,
  output logic empty
);
  import plcbp_pkg::*;
  typedef struct packed {
    logic [BRK_DEPTH-1:0] rlo;
    logic [BRK_DEPTH-1:0] op_or;
    logic [BRK_W-1:0] depth;
  } plcbp_stk_t;
  plcbp_stk_t stk_q;
  plcbp_stk_t stk_d;
  logic [BRK_W-1:0] top_idx;

  assign full = (stk_q.depth == BRK_W'(BRK_DEPTH));
  assign empty = (stk_q.depth == '0);
  assign depth = stk_q.depth;
  assign top_idx = empty ? '0 : stk_q.depth - 3'h1;
  assign top_rlo = stk_q.rlo[top_idx];
  assign top_op_or = stk_q.op_or[top_idx];

  always_comb begin
    stk_d = stk_q;
    if (push && !full) begin
      stk_d.rlo[stk_q.depth] = push_rlo;
      stk_d.op_or[stk_q.depth] = push_op_or;
      stk_d.depth = stk_q.depth + 3'h1;
    end else if (pop && !empty) begin
      stk_d.depth = stk_q.depth - 3'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      stk_q <= '0;
    end else begin
      stk_q <= stk_d;
    end
  end
endmodule

// ===== hw/plcbp_dispatch.sv
// Bit processor: fetch, decode, logic unit, word hand-over, address counter.
`timescale 1ns/100ps
module plcbp_dispatch (
  input wire logic clk_sys,
  input wire logic reset,
  output logic [plcbp_pkg::ADDR_W-1:0] mem_addr,
  output logic mem_rd,
  input wire logic mem_ack,
  input wire logic [plcbp_pkg::CMD_W-1:0] mem_data,
  output logic [plcbp_pkg::PAR_W-1:0] bit_addr,
  output logic bit_rd,
  output logic bit_wr,
  output logic bit_wdata,
  input wire logic bit_rdata,
  output logic io_req,
  output logic [plcbp_pkg::PAR_W-1:0] io_addr,
  input wire logic io_ack,
  output logic word_req,
  output logic [plcbp_pkg::ADDR_W-1:0] word_entry,
  output logic [plcbp_pkg::PAR_W-1:0] word_param,
  input wire logic word_done,
  output logic [plcbp_pkg::ADDR_W-1:0] pc_value,
  input wire logic pc_load,
  input wire logic [plcbp_pkg::ADDR_W-1:0] pc_target,
  input wire logic int_line,
  input wire logic [plcbp_pkg::EVT_W-1:0] evt_in,
  input wire logic evt_clear,
  output logic [plcbp_pkg::EVT_W-1:0] evt_reg,
  output logic int_pending,
  output logic [plcbp_pkg::CTL_W-1:0] ctl_bits,
  output logic rlo,
  output logic [plcbp_pkg::BRK_W-1:0] brk_depth,
  output logic brk_error
);
  import plcbp_pkg::*;
  typedef enum logic [2:0] {
    ST_FETCH, ST_WAIT, ST_EXEC, ST_IO, ST_WORD
  } plcbp_st_t;
  typedef struct packed {
    plcbp_st_t st;
    logic [ADDR_W-1:0] pc;
    logic [OPC_W-1:0] opc;
    logic [PAR_W-1:0] par;
    logic [UPC_W-1:0] upc;
    logic rlo;
    logic first;
    logic [EVT_W-1:0] evt;
    logic [2:0] int_sync;
    logic int_lvl;
    logic brk_err;
  } plcbp_state_t;
  plcbp_state_t s_q;
  plcbp_state_t s_d;
  logic [CTL_W-1:0] ctl;
  logic push;
  logic pop;
  logic top_or;
  logic top_rlo;
  logic stk_full;
  logic stk_empty;

  // First table: opcode group to microprogram entry.
  function automatic logic [UPC_W-1:0] map_entry(input logic [OPC_W-1:0] op);
    unique case (op[7:4])
      OPG_AND, OPG_OR, OPG_LOAD: map_entry = UPC_LOGIC;
      OPG_SET, OPG_RESET, OPG_ASSIGN: map_entry = UPC_STORE;
      OPG_ANDOPEN, OPG_OROPEN, OPG_CLOSE: map_entry = UPC_BRK;
      OPG_IO: map_entry = UPC_IO;
      default: map_entry = UPC_WORD;
    endcase
  endfunction

  // Microprogram store: control bits per step.
  function automatic logic [CTL_W-1:0] ustore(input logic [UPC_W-1:0] u);
    logic [CTL_W-1:0] c;
    c = '0;
    unique case (u)
      UPC_LOGIC: c = CTL_W'(1) << CTL_READ_OP;
      UPC_LOGIC + 4'h1: c = (CTL_W'(1) << CTL_LOGIC) | (CTL_W'(1) << CTL_STEP);
      UPC_STORE: c = (CTL_W'(1) << CTL_WRITE_BIT) | (CTL_W'(1) << CTL_STEP);
      UPC_BRK: c = (CTL_W'(1) << CTL_BRK) | (CTL_W'(1) << CTL_STEP);
      UPC_WORD: c = CTL_W'(1) << CTL_WORD;
      UPC_IO: c = CTL_W'(1) << CTL_IO;
      UPC_END: c = CTL_W'(1) << CTL_DONE;
      default: c = '0;
    endcase
    return c;
  endfunction

  assign ctl = (s_q.st == ST_EXEC) ? ustore(s_q.upc) : '0;

  // Second table: word command opcode to byte processor routine.
  assign word_entry = {{(ADDR_W-OPC_W-2){1'b0}}, s_q.opc, 2'b00};

  assign push = ctl[CTL_BRK] && (s_q.opc[7:4] != OPG_CLOSE);
  assign pop = ctl[CTL_BRK] && (s_q.opc[7:4] == OPG_CLOSE);

  plcbp_bracket_stack u_stack (
    .clk_sys(clk_sys),
    .reset(reset),
    .push(push),
    .push_op_or(s_q.opc[7:4] == OPG_OROPEN),
    .push_rlo(s_q.rlo),
    .pop(pop),
    .depth(brk_depth),
    .top_op_or(top_or),
    .top_rlo(top_rlo),
    .full(stk_full),
    .empty(stk_empty)
  );

  always_comb begin
    s_d = s_q;
    s_d.int_sync = {s_q.int_sync[1:0], int_line};
    if (s_q.int_sync[2] == s_q.int_sync[1]) begin
      s_d.int_lvl = s_q.int_sync[2];
    end
    if (evt_clear) begin
      s_d.evt = '0;
    end
    s_d.evt = s_d.evt | evt_in;
    if (s_q.int_lvl) begin
      s_d.evt[EVT_HW_INT] = 1'b1;
    end
    unique case (s_q.st)
      ST_FETCH: begin
        if (!s_q.int_lvl) begin
          s_d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (mem_ack) begin
          s_d.opc = mem_data[OPC_LSB +: OPC_W];
          s_d.par = mem_data[PAR_W-1:0];
          s_d.upc = map_entry(mem_data[OPC_LSB +: OPC_W]);
          s_d.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        s_d.upc = s_q.upc + 4'h1;
        if (ctl[CTL_LOGIC]) begin
          unique case (s_q.opc[7:4])
            OPG_AND: s_d.rlo = s_q.first ? bit_rdata : s_q.rlo & bit_rdata;
            OPG_OR: s_d.rlo = s_q.first ? bit_rdata : s_q.rlo | bit_rdata;
            default: s_d.rlo = bit_rdata;
          endcase
          s_d.first = 1'b0;
        end
        if (ctl[CTL_WRITE_BIT]) begin
          s_d.first = 1'b1;
        end
        if (ctl[CTL_BRK]) begin
          if (pop) begin
            s_d.rlo = top_or ? (top_rlo | s_q.rlo) : (top_rlo & s_q.rlo);
            s_d.brk_err = s_q.brk_err | stk_empty;
            s_d.first = 1'b0;
          end else begin
            s_d.first = 1'b1;
            s_d.brk_err = s_q.brk_err | stk_full;
          end
        end
        if (ctl[CTL_STEP]) begin
          s_d.pc = s_q.pc + 15'h0001;
          s_d.st = ST_FETCH;
        end
        if (ctl[CTL_WORD]) begin
          s_d.st = ST_WORD;
        end
        if (ctl[CTL_IO]) begin
          s_d.st = ST_IO;
        end
      end
      ST_IO: begin
        if (io_ack) begin
          s_d.pc = s_q.pc + 15'h0001;
          s_d.st = ST_FETCH;
        end
      end
      ST_WORD: begin
        if (word_done) begin
          s_d.pc = pc_load ? pc_target : s_q.pc + 15'h0001;
          s_d.st = ST_FETCH;
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      s_q <= '0;
      s_q.st <= ST_FETCH;
      s_q.pc <= ADDR_RST;
      s_q.evt <= EVT_RST;
      s_q.first <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign mem_addr = s_q.pc;
  assign mem_rd = (s_q.st == ST_WAIT);
  assign bit_addr = s_q.par;
  assign bit_rd = ctl[CTL_READ_OP] | ctl[CTL_LOGIC];
  assign bit_wr = ctl[CTL_WRITE_BIT] &&
                  !((s_q.opc[7:4] == OPG_SET || s_q.opc[7:4] == OPG_RESET)
                    && !s_q.rlo);
  assign bit_wdata = (s_q.opc[7:4] == OPG_RESET) ? 1'b0 : s_q.rlo;
  assign io_req = (s_q.st == ST_IO);
  assign io_addr = s_q.par;
  assign word_req = (s_q.st == ST_WORD);
  assign word_param = s_q.par;
  assign pc_value = s_q.pc;
  assign evt_reg = s_q.evt;
  assign int_pending = s_q.int_lvl;
  assign ctl_bits = ctl;
  assign rlo = s_q.rlo;
  assign brk_error = s_q.brk_err;
endmodule

// ===== tb/plcbp_partner.sv
// Model of program memory, bit memory, I/O and byte processor.
`timescale 1ns/100ps
module plcbp_partner (
  input wire logic clk_sys,
  input wire logic [14:0] mem_addr,
  input wire logic mem_rd,
  output logic mem_ack,
  output logic [15:0] mem_data,
  input wire logic [7:0] bit_addr,
  input wire logic bit_wr,
  input wire logic bit_wdata,
  output logic bit_rdata,
  input wire logic io_req,
  output logic io_ack,
  input wire logic word_req,
  input wire logic [7:0] word_param,
  output logic word_done,
  output logic pc_load,
  output logic [14:0] pc_target
);
  logic [15:0] rom [0:255];
  logic [255:0] bits;
  logic [1:0] wcnt;
  initial begin
    mem_ack = 1'h0;
    io_ack = 1'h0;
    word_done = 1'h0;
    wcnt = 2'h0;
  end
  assign mem_data = mem_ack ? rom[mem_addr[7:0]] : ~rom[mem_addr[7:0]];
  assign bit_rdata = bits[bit_addr];
  always @(posedge clk_sys) begin
    mem_ack <= mem_rd && !mem_ack;
    io_ack <= io_req && !io_ack;
    wcnt <= (word_req && !word_done) ? wcnt + 2'h1 : 2'h0;
    word_done <= word_req && !word_done && wcnt == 2'h2;
    if (bit_wr) begin
      bits[bit_addr] <= bit_wdata;
    end
  end
  assign pc_load = word_done && word_param[7];
  assign pc_target = {7'h00, word_done ? word_param : ~word_param};
endmodule

// ===== tb/plcbp_dispatch_properties.sv
// Assertions on the ports of the bit processor dispatch block.
`timescale 1ns/100ps
module plcbp_dispatch_properties
  import plcbp_pkg::*;
(
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic mem_rd,
  input wire logic word_req,
  input wire logic word_done,
  input wire logic io_ack,
  input wire logic pc_load,
  input wire logic [14:0] pc_target,
  input wire logic [14:0] pc_value,
  input wire logic int_pending,
  input wire logic [7:0] evt_in,
  input wire logic [7:0] evt_reg,
  input wire logic [2:0] brk_depth,
  input wire logic [7:0] ctl_bits
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_rst;
    $fell(reset) |-> {pc_value, evt_reg, brk_depth} == 26'h0;
  endproperty
  a_rst: assert property (p_rst) else $error("state not cleared");
  property p_stall;
    word_req |-> !mem_rd;
  endproperty
  a_stall: assert property (p_stall) else $error("fetch in word");
  property p_pc;
    $changed(pc_value) && !$past(reset)
      |-> $past(ctl_bits[CTL_STEP]) || $past(word_done) || $past(io_ack);
  endproperty
  a_pc: assert property (p_pc) else $error("counter moved");
  property p_jmp;
    word_done && pc_load |=> pc_value == $past(pc_target);
  endproperty
  a_jmp: assert property (p_jmp) else $error("jump missed");
  property p_int;
    int_pending && !mem_rd |=> !mem_rd;
  endproperty
  a_int: assert property (p_int) else $error("fetch in interrupt");
  property p_hwi;
    int_pending |=> evt_reg[EVT_HW_INT];
  endproperty
  a_hwi: assert property (p_hwi) else $error("line not recorded");
  property p_evt;
    evt_in != 8'h00 |=> (evt_reg & $past(evt_in)) == $past(evt_in);
  endproperty
  a_evt: assert property (p_evt) else $error("event lost");
  property p_brk;
    $changed(brk_depth) && !$past(reset) |-> brk_depth ==
      $past(brk_depth) + 3'h1 || $past(brk_depth) == brk_depth + 3'h1;
  endproperty
  a_brk: assert property (p_brk) else $error("depth jumped");
endmodule
bind plcbp_dispatch plcbp_dispatch_properties u_props (.*);

// ===== tb/test_plc_bit_processor_dispatch.sv
// Self-checking bench of the bit processor dispatch block.
`timescale 1ns/100ps
module test_plc_bit_processor_dispatch;
  import plcbp_pkg::*;
  logic clk_sys = 1'h0;
  logic reset = 1'h1;
  logic int_line = 1'h0;
  logic evt_clear = 1'h0;
  logic [7:0] evt_in = 8'h00;
  logic [14:0] mem_addr, word_entry, pc_value, pc_target;
  logic [15:0] mem_data;
  logic [7:0] bit_addr, io_addr, word_param, evt_reg, ctl_bits;
  logic [2:0] brk_depth;
  logic mem_rd, mem_ack, bit_rd, bit_wr, bit_wdata, bit_rdata, io_req;
  logic io_ack, word_req, word_done, pc_load, int_pending, rlo, brk_error;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  always #2 clk_sys = ~clk_sys;
  plcbp_dispatch dut (.*);
  plcbp_partner u_part (.*);
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    n_checks++;
    if (s !== e) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic conclude();
    if (error_cnt == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic start(logic [15:0] p [$]);
    foreach (u_part.rom[i]) u_part.rom[i] = 16'h0000;
    foreach (p[i]) u_part.rom[i] = p[i];
    u_part.bits = 256'h6002;
    @(posedge clk_sys);
    reset <= 1'h1;
    repeat (10) @(posedge clk_sys);
    reset <= 1'h0;
    @(posedge clk_sys);
    #1 chk("reset_state", 16'h0, {pc_value[7:0], evt_reg});
  endtask
  task automatic upto(logic [14:0] a);
    @(posedge clk_sys iff pc_value === a);
    #1;
  endtask
  task automatic t_logic();
    start('{16'h3001, 16'h1002, 16'h900A, 16'h2001, 16'h900B, 16'h400C,
      16'h500D, 16'h900E});
    upto(15'h8);
    chk("bits_14_10", 16'h16, u_part.bits[14:10]);
    chk("rlo", 16'h1, rlo);
  endtask
  task automatic t_brk();
    start('{16'h3002, 16'h6000, 16'h3002, 16'h2001, 16'h8000, 16'h900E,
      16'h7000, 16'h3001, 16'h8000, 16'h900F});
    upto(15'h6);
    chk("bit_14", 16'h0, u_part.bits[14]);
    upto(15'hA);
    chk("bit_15", 16'h1, u_part.bits[15]);
    start('{16'h6000, 16'h6000, 16'h6000, 16'h6000, 16'h6000, 16'h6000,
      16'h6000, 16'h6000});
    upto(15'h8);
    chk("brk_state", 16'hF, {brk_depth, brk_error});
  endtask
  task automatic t_word();
    start('{16'h0580});
    u_part.rom[8'h80] = 16'hA033;
    @(posedge clk_sys iff word_req === 1'h1);
    #1 chk("word_entry", 16'h0014, word_entry);
    chk("word_param", 16'h0080, word_param);
    upto(15'h80);
    @(posedge clk_sys iff io_req === 1'h1);
    #1 chk("io_addr", 16'h0033, io_addr);
    upto(15'h81);
  endtask
  task automatic t_int();
    start('{16'h0000});
    int_line <= 1'h1;
    @(posedge clk_sys iff int_pending === 1'h1);
    evt_in <= 8'h04;
    @(posedge clk_sys);
    evt_in <= 8'h00;
    repeat (3) @(posedge clk_sys);
    #1 chk("mem_rd", 16'h0, mem_rd);
    @(posedge clk_sys);
    int_line <= 1'h0;
    repeat (8) @(posedge clk_sys);
    evt_clear <= 1'h1;
    #1 chk("evt_reg", 16'h05, evt_reg);
    chk("pc_hold", 16'h0001, pc_value);
    @(posedge clk_sys);
    evt_clear <= 1'h0;
    @(posedge clk_sys);
    #1 chk("evt_clr", 16'h00, evt_reg);
  endtask
  initial begin
    t_logic();
    t_brk();
    t_word();
    t_int();
    conclude();
  end
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      error_cnt++;
      conclude();
    end
  end
endmodule
